// ---- logic/port_defines.svh ----
// Offsets, field positions and reset values of the parallel port block
`ifndef PORT_DEFINES_SVH
`define PORT_DEFINES_SVH

`define OFS_PORT_A_PIN_VALUE 16'h0000
`define OFS_PORT_B_PIN_VALUE 16'h0001
`define OFS_PORT_C_PIN_VALUE 16'h0002
`define OFS_STRONG_DRIVE_SELECT 16'h30af
`define OFS_PORT_A_DRIVER_ENABLE 16'h30b0
`define OFS_PORT_B_DRIVER_ENABLE 16'h30b1
`define OFS_PORT_C_DRIVER_ENABLE 16'h30b2
`define OFS_PORT_A_INPUT_GATE 16'h30b8
`define OFS_PORT_B_INPUT_GATE 16'h30b9
`define OFS_PORT_C_INPUT_GATE 16'h30ba
`define OFS_PORT_A_ANALOG_SELECT 16'h3100
`define OFS_PORT_B_ANALOG_SELECT 16'h3101
`define OFS_PORT_C_ANALOG_SELECT 16'h3102

`define PORT_A_WIDTH 6
`define PORT_B_WIDTH 8
`define PORT_C_WIDTH 4
`define STRONG_LINE_FIVE_BIT 1
`define STRONG_LINE_FOUR_BIT 0
`define PORT_B_LINE_FIVE 5
`define PORT_B_LINE_FOUR 4
`define REG_RESET 8'h00

`endif

// ---- logic/port_pkg.sv ----
// Types shared by the parallel port block
`default_nettype none
package port_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] addr_t;
    typedef enum logic [1:0] {
        PORT_SEL_A,
        PORT_SEL_B,
        PORT_SEL_C
    } port_sel_t;
endpackage : port_pkg
`default_nettype wire

// ---- logic/port_lane.sv ----
// One parallel port: data, driver/input gates, analog select and read-back mux
`timescale 1ns/10ps
`default_nettype none
`include "port_defines.svh"
module port_lane #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst_sync_n,
    input wire logic wr_data_en,
    input wire logic wr_oe_en,
    input wire logic wr_ie_en,
    input wire logic wr_an_en,
    input wire logic [W-1:0] wr_val,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] data_q,
    output logic [W-1:0] oe_q,
    output logic [W-1:0] ie_q,
    output logic [W-1:0] an_q,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] rd_val
);
    // Data latch takes every write regardless of direction
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            data_q <= '0;
        end else if (wr_data_en) begin
            data_q <= wr_val;
        end
    end

    // Direction and analog controls all reset to released pins
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            oe_q <= '0;
            ie_q <= '0;
            an_q <= '0;
        end else begin
            if (wr_oe_en) oe_q <= wr_val;
            if (wr_ie_en) ie_q <= wr_val;
            if (wr_an_en) an_q <= wr_val;
        end
    end

    // Pin drive registered so outputs come from flops; analog owns the pin
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge core_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                pin_out[i] <= 1'b0;
                pin_oe[i] <= 1'b0;
            end else begin
                pin_out[i] <= (wr_data_en ? wr_val[i] : data_q[i]);
                pin_oe[i] <= (wr_oe_en ? wr_val[i] : oe_q[i]) & ~(wr_an_en ? wr_val[i] : an_q[i]);
            end
        end
        // Read-back: analog zero, output wins over input, Hi-Z shows latch
        always_comb begin
            if (an_q[i]) begin
                rd_val[i] = 1'b0;
            end else if (oe_q[i]) begin
                rd_val[i] = data_q[i];
            end else if (ie_q[i]) begin
                rd_val[i] = pin_in[i];
            end else begin
                rd_val[i] = data_q[i];
            end
        end
    end
endmodule : port_lane
`default_nettype wire

// ---- logic/parallel_port.sv ----
// Top of the three-port parallel I/O block with its register port
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "port_defines.svh"
module parallel_port (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire port_pkg::addr_t reg_addr,
    input wire port_pkg::byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output port_pkg::byte_t reg_rdata,
    input wire logic [`PORT_A_WIDTH-1:0] port_a_pin_in,
    output logic [`PORT_A_WIDTH-1:0] port_a_pin_out,
    output logic [`PORT_A_WIDTH-1:0] port_a_pin_oe,
    input wire logic [`PORT_B_WIDTH-1:0] port_b_pin_in,
    output logic [`PORT_B_WIDTH-1:0] port_b_pin_out,
    output logic [`PORT_B_WIDTH-1:0] port_b_pin_oe,
    input wire logic [`PORT_C_WIDTH-1:0] port_c_pin_in,
    output logic [`PORT_C_WIDTH-1:0] port_c_pin_out,
    output logic [`PORT_C_WIDTH-1:0] port_c_pin_oe,
    output logic port_b_line_five_strong,
    output logic port_b_line_four_strong
);
    localparam int AW = `PORT_A_WIDTH;
    localparam int BW = `PORT_B_WIDTH;
    localparam int CW = `PORT_C_WIDTH;

    logic rst_meta_q;
    logic rst_sync_n;

    // Reset released through two flops; asserted at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // Write decode
    logic wr_a_d, wr_b_d, wr_c_d;
    logic oe_a_w, oe_b_w, oe_c_w;
    logic ie_a_w, ie_b_w, ie_c_w;
    logic an_a_w, an_b_w, an_c_w;
    logic wr_strong;
    assign wr_a_d = reg_wr && (reg_addr == `OFS_PORT_A_PIN_VALUE);
    assign wr_b_d = reg_wr && (reg_addr == `OFS_PORT_B_PIN_VALUE);
    assign wr_c_d = reg_wr && (reg_addr == `OFS_PORT_C_PIN_VALUE);
    assign oe_a_w = reg_wr && (reg_addr == `OFS_PORT_A_DRIVER_ENABLE);
    assign oe_b_w = reg_wr && (reg_addr == `OFS_PORT_B_DRIVER_ENABLE);
    assign oe_c_w = reg_wr && (reg_addr == `OFS_PORT_C_DRIVER_ENABLE);
    assign ie_a_w = reg_wr && (reg_addr == `OFS_PORT_A_INPUT_GATE);
    assign ie_b_w = reg_wr && (reg_addr == `OFS_PORT_B_INPUT_GATE);
    assign ie_c_w = reg_wr && (reg_addr == `OFS_PORT_C_INPUT_GATE);
    assign an_a_w = reg_wr && (reg_addr == `OFS_PORT_A_ANALOG_SELECT);
    assign an_b_w = reg_wr && (reg_addr == `OFS_PORT_B_ANALOG_SELECT);
    assign an_c_w = reg_wr && (reg_addr == `OFS_PORT_C_ANALOG_SELECT);
    assign wr_strong = reg_wr && (reg_addr == `OFS_STRONG_DRIVE_SELECT);

    logic [AW-1:0] a_data, a_oe, a_ie, a_an, a_rd;
    logic [BW-1:0] b_data, b_oe, b_ie, b_an, b_rd;
    logic [CW-1:0] c_data, c_oe, c_ie, c_an, c_rd;

    // Narrow ports drop the upper write bits, so they never store
    port_lane #(.W(AW)) u_port_a (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .wr_data_en(wr_a_d),
        .wr_oe_en(oe_a_w),
        .wr_ie_en(ie_a_w),
        .wr_an_en(an_a_w),
        .wr_val(reg_wdata[AW-1:0]),
        .pin_in(port_a_pin_in),
        .data_q(a_data),
        .oe_q(a_oe),
        .ie_q(a_ie),
        .an_q(a_an),
        .pin_out(port_a_pin_out),
        .pin_oe(port_a_pin_oe),
        .rd_val(a_rd)
    );

    port_lane #(.W(BW)) u_port_b (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .wr_data_en(wr_b_d),
        .wr_oe_en(oe_b_w),
        .wr_ie_en(ie_b_w),
        .wr_an_en(an_b_w),
        .wr_val(reg_wdata[BW-1:0]),
        .pin_in(port_b_pin_in),
        .data_q(b_data),
        .oe_q(b_oe),
        .ie_q(b_ie),
        .an_q(b_an),
        .pin_out(port_b_pin_out),
        .pin_oe(port_b_pin_oe),
        .rd_val(b_rd)
    );

    port_lane #(.W(CW)) u_port_c (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .wr_data_en(wr_c_d),
        .wr_oe_en(oe_c_w),
        .wr_ie_en(ie_c_w),
        .wr_an_en(an_c_w),
        .wr_val(reg_wdata[CW-1:0]),
        .pin_in(port_c_pin_in),
        .data_q(c_data),
        .oe_q(c_oe),
        .ie_q(c_ie),
        .an_q(c_an),
        .pin_out(port_c_pin_out),
        .pin_oe(port_c_pin_oe),
        .rd_val(c_rd)
    );

    // Strong-drive select, only two bits implemented
    logic [1:0] strong_q;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strong_q <= 2'h0;
        end else if (wr_strong) begin
            strong_q <= reg_wdata[1:0];
        end
    end

    // Strong drive gated by the line's driver enable bit alone, even on an analog-selected line
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            port_b_line_five_strong <= 1'b0;
            port_b_line_four_strong <= 1'b0;
        end else begin
            port_b_line_five_strong <= strong_q[`STRONG_LINE_FIVE_BIT] && b_oe[`PORT_B_LINE_FIVE];
            port_b_line_four_strong <= strong_q[`STRONG_LINE_FOUR_BIT] && b_oe[`PORT_B_LINE_FOUR];
        end
    end

    // Read mux; unused upper bits and unmapped offsets return zero
    port_pkg::byte_t rd_mux;
    always_comb begin
        rd_mux = `REG_RESET;
        unique case (reg_addr)
            `OFS_PORT_A_PIN_VALUE: rd_mux = {2'h0, a_rd};
            `OFS_PORT_B_PIN_VALUE: rd_mux = b_rd;
            `OFS_PORT_C_PIN_VALUE: rd_mux = {4'h0, c_rd};
            `OFS_STRONG_DRIVE_SELECT: rd_mux = {6'h00, strong_q};
            `OFS_PORT_A_DRIVER_ENABLE: rd_mux = {2'h0, a_oe};
            `OFS_PORT_B_DRIVER_ENABLE: rd_mux = b_oe;
            `OFS_PORT_C_DRIVER_ENABLE: rd_mux = {4'h0, c_oe};
            `OFS_PORT_A_INPUT_GATE: rd_mux = {2'h0, a_ie};
            `OFS_PORT_B_INPUT_GATE: rd_mux = b_ie;
            `OFS_PORT_C_INPUT_GATE: rd_mux = {4'h0, c_ie};
            `OFS_PORT_A_ANALOG_SELECT: rd_mux = {2'h0, a_an};
            `OFS_PORT_B_ANALOG_SELECT: rd_mux = b_an;
            `OFS_PORT_C_ANALOG_SELECT: rd_mux = {4'h0, c_an};
            default: rd_mux = `REG_RESET;
        endcase
    end

    // Read data registered, valid only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= `REG_RESET;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= `REG_RESET;
        end
    end

    // Checks
    property p_data_write;
        @(posedge core_clk) disable iff (!rst_sync_n)
        wr_b_d |=> (b_data == $past(reg_wdata));
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write not latched");

    property p_drive_follows;
        @(posedge core_clk) disable iff (!rst_sync_n)
        ##1 (port_a_pin_oe == (a_oe & ~a_an)) && ((port_a_pin_out & port_a_pin_oe) == (a_data & port_a_pin_oe));
    endproperty
    a_drive_follows: assert property (p_drive_follows) else $error("pin drive mismatch");

    property p_read_output;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (reg_rd && reg_addr == `OFS_PORT_B_PIN_VALUE && !wr_b_d) |=>
            ((reg_rdata & $past(b_oe & ~b_an)) == ($past(b_data & b_oe & ~b_an)));
    endproperty
    a_read_output: assert property (p_read_output) else $error("output read-back wrong");

    property p_read_input;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (reg_rd && reg_addr == `OFS_PORT_C_PIN_VALUE) |=>
            ((reg_rdata[3:0] & $past(c_ie & ~c_oe & ~c_an)) == $past(port_c_pin_in & c_ie & ~c_oe & ~c_an));
    endproperty
    a_read_input: assert property (p_read_input) else $error("input read-back wrong");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (reg_rd && (reg_addr == `OFS_PORT_A_PIN_VALUE || reg_addr == `OFS_PORT_A_DRIVER_ENABLE))
            |=> (reg_rdata[7:6] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_analog_zero;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (reg_rd && reg_addr == `OFS_PORT_B_PIN_VALUE) |=> ((reg_rdata & $past(b_an)) == 8'h00);
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog bit not zero");

    property p_off_undriven;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!a_oe[0] && !oe_a_w) |=> !port_a_pin_oe[0];
    endproperty
    a_off_undriven: assert property (p_off_undriven) else $error("disabled pin driven");

    property p_strong_gate;
        @(posedge core_clk) disable iff (!rst_sync_n)
        ##1 (port_b_line_five_strong == $past(strong_q[1] && b_oe[5]));
    endproperty
    a_strong_gate: assert property (p_strong_gate) else $error("strong drive mismatch");

    property p_reset_quiet;
        @(posedge core_clk)
        $rose(rst_sync_n) |-> (port_b_pin_oe == 8'h00 && b_data == 8'h00);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset not quiet");

    // While held in reset the port A and C data latches are clear and those pins are not driven
    property p_reset_clear;
        @(posedge core_clk)
        !rst_sync_n |-> (a_data == 6'h00 && c_data == 4'h0 && port_a_pin_oe == 6'h00 && port_c_pin_oe == 4'h0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left a pin or latch set");

    // Read data fall back to zero outside the answer cycle
    property p_rdata_idle;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !reg_rd |=> (reg_rdata == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    // Port C data and driver enable registers keep their upper nibble at zero
    property p_reserved_narrow;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (reg_rd && (reg_addr == `OFS_PORT_C_PIN_VALUE || reg_addr == `OFS_PORT_C_DRIVER_ENABLE))
            |=> (reg_rdata[7:4] == 4'h0);
    endproperty
    a_reserved_narrow: assert property (p_reserved_narrow) else $error("port c upper bits not zero");

    property p_reserved_strong;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (reg_rd && reg_addr == `OFS_STRONG_DRIVE_SELECT) |=> (reg_rdata[7:2] == 6'h00);
    endproperty
    a_reserved_strong: assert property (p_reserved_strong) else $error("strong upper bits not zero");

    // A latch only moves on its own write, so a stray decode shows here
    property p_data_hold;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !wr_a_d |=> $stable(a_data);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("port a data moved without a write");

    property p_strong_four;
        @(posedge core_clk) disable iff (!rst_sync_n)
        ##1 (port_b_line_four_strong == $past(strong_q[0] && b_oe[4]));
    endproperty
    a_strong_four: assert property (p_strong_four) else $error("strong drive four mismatch");

    // Analog-selected lines of ports B and C are never driven
    property p_analog_undriven;
        @(posedge core_clk) disable iff (!rst_sync_n)
        ((port_c_pin_oe & c_an) == 4'h0) && ((port_b_pin_oe & b_an) == 8'h00);
    endproperty
    a_analog_undriven: assert property (p_analog_undriven) else $error("analog line driven");

    c_write_then_enable: cover property (@(posedge core_clk) disable iff (!rst_sync_n) wr_a_d ##[1:4] oe_a_w);
    c_input_read: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
        reg_rd && reg_addr == `OFS_PORT_C_PIN_VALUE && c_ie != 4'h0);
    c_strong_on: cover property (@(posedge core_clk) disable iff (!rst_sync_n) port_b_line_five_strong);
    c_analog_read: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
        reg_rd && reg_addr == `OFS_PORT_B_PIN_VALUE && b_an != 8'h00);
endmodule : parallel_port
`default_nettype wire

// ---- tb/pin_model.sv ----
// External pin model: driven lines follow the block, others take the outside level
`timescale 1ns/10ps
`default_nettype none
module pin_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] ext_level,
    output logic [W-1:0] pin_in
);
    // Wire level per line; an enabled driver wins, so tests avoid contention
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    end
endmodule : pin_model
`default_nettype wire

// ---- tb/parallel_port_data_and_drive_test.sv ----
// Register-sequence testbench for the three-port parallel I/O block
`timescale 1ns/10ps
`default_nettype none
`include "port_defines.svh"
module parallel_port_data_and_drive_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    port_pkg::addr_t reg_addr = 16'h0000;
    port_pkg::byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    port_pkg::byte_t reg_rdata;
    logic [5:0] a_in, a_out, a_oe, a_ext;
    logic [7:0] b_in, b_out, b_oe, b_ext;
    logic [3:0] c_in, c_out, c_oe, c_ext;
    logic five_strong, four_strong;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    parallel_port u_parallel_port (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_a_pin_in(a_in), .port_a_pin_out(a_out), .port_a_pin_oe(a_oe),
        .port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_pin_oe(b_oe),
        .port_c_pin_in(c_in), .port_c_pin_out(c_out), .port_c_pin_oe(c_oe),
        .port_b_line_five_strong(five_strong), .port_b_line_four_strong(four_strong));
    pin_model #(.W(6)) u_pin_model_a (.pin_out(a_out), .pin_oe(a_oe), .ext_level(a_ext), .pin_in(a_in));
    pin_model #(.W(8)) u_pin_model_b (.pin_out(b_out), .pin_oe(b_oe), .ext_level(b_ext), .pin_in(b_in));
    pin_model #(.W(4)) u_pin_model_c (.pin_out(c_out), .pin_oe(c_oe), .ext_level(c_ext), .pin_in(c_in));

    // Outside levels chosen unlike any latch value so a wrong source shows
    initial begin
        a_ext = 6'h2a;
        b_ext = 8'ha5;
        c_ext = 4'h9;
    end

    // 250 MHz clock
    always #2 core_clk = ~core_clk;

    // Hang guard, far above the hundred-odd cycles the sequence needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input port_pkg::byte_t exp, input port_pkg::byte_t got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One-cycle write strobe; pins settle at the taking edge
    task automatic reg_write(input port_pkg::addr_t a, input port_pkg::byte_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe
    task automatic reg_read_chk(input string what, input port_pkg::addr_t a, input port_pkg::byte_t exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : reg_read_chk

    // Strong-drive lines follow their register one edge later
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask : do_reset

    // Data, strong and port A driver enable registers read zero and no pin is driven
    task automatic reset_state();
        reg_read_chk("a data", `OFS_PORT_A_PIN_VALUE, 8'h00);
        reg_read_chk("b data", `OFS_PORT_B_PIN_VALUE, 8'h00);
        reg_read_chk("c data", `OFS_PORT_C_PIN_VALUE, 8'h00);
        reg_read_chk("strong", `OFS_STRONG_DRIVE_SELECT, 8'h00);
        reg_read_chk("a oe", `OFS_PORT_A_DRIVER_ENABLE, 8'h00);
        chk("pins oe", 8'h00, {2'h0, a_oe} | b_oe | {4'h0, c_oe});
        chk("strong out", 8'h00, {6'h0, five_strong, four_strong});
    endtask : reset_state

    initial begin
        do_reset();
        reset_state();
        // Data before driver enable, so no stale value reaches a pin
        reg_write(`OFS_PORT_A_PIN_VALUE, 8'hff);
        chk("a oe undriven", 8'h00, {2'h0, a_oe});
        reg_write(`OFS_PORT_A_DRIVER_ENABLE, 8'hff);
        reg_read_chk("a oe reserved", `OFS_PORT_A_DRIVER_ENABLE, 8'h3f);
        chk("a pin oe", 8'h3f, {2'h0, a_oe});
        chk("a pin out", 8'h3f, {2'h0, a_out});
        reg_read_chk("a out readback", `OFS_PORT_A_PIN_VALUE, 8'h3f);
        reg_write(`OFS_PORT_A_DRIVER_ENABLE, 8'h15);
        chk("a partial oe", 8'h15, {2'h0, a_oe});
        chk("a partial out", 8'h15, {2'h0, a_out & a_oe});
        // Port B input from the outside while the latch holds another value
        reg_write(`OFS_PORT_B_PIN_VALUE, 8'h3c);
        reg_write(`OFS_PORT_B_INPUT_GATE, 8'hff);
        reg_read_chk("b input", `OFS_PORT_B_PIN_VALUE, 8'ha5);
        chk("b undriven", 8'h00, b_oe);
        // Both gates on the low nibble: latch wins there
        reg_write(`OFS_PORT_B_DRIVER_ENABLE, 8'h0f);
        reg_read_chk("b mixed", `OFS_PORT_B_PIN_VALUE, 8'hac);
        chk("b pin out", 8'h0c, b_out & b_oe);
        // Strong drive on lines five and four, driven as outputs
        reg_write(`OFS_PORT_B_DRIVER_ENABLE, 8'h30);
        reg_write(`OFS_STRONG_DRIVE_SELECT, 8'hff);
        reg_read_chk("strong reserved", `OFS_STRONG_DRIVE_SELECT, 8'h03);
        chk("strong both", 8'h03, {6'h0, five_strong, four_strong});
        reg_write(`OFS_STRONG_DRIVE_SELECT, 8'h01);
        tick();
        chk("strong four only", 8'h01, {6'h0, five_strong, four_strong});
        reg_write(`OFS_STRONG_DRIVE_SELECT, 8'h02);
        tick();
        chk("strong five only", 8'h02, {6'h0, five_strong, four_strong});
        // Analog line zero, driven lines latch, the rest the outside level
        reg_write(`OFS_PORT_B_ANALOG_SELECT, 8'h01);
        reg_read_chk("b analog", `OFS_PORT_B_PIN_VALUE, 8'hb4);
        // Port C latched while undriven, then enabled
        reg_write(`OFS_PORT_C_PIN_VALUE, 8'hff);
        reg_write(`OFS_PORT_C_DRIVER_ENABLE, 8'h0f);
        reg_read_chk("c readback", `OFS_PORT_C_PIN_VALUE, 8'h0f);
        chk("c pin out", 8'h0f, {4'h0, c_out & c_oe});
        reg_write(`OFS_PORT_C_ANALOG_SELECT, 8'h01);
        reg_read_chk("c analog", `OFS_PORT_C_PIN_VALUE, 8'h0e);
        // Upper lines turn to inputs, bit 1 stays output, bit 0 analog
        reg_write(`OFS_PORT_C_INPUT_GATE, 8'h0f);
        reg_write(`OFS_PORT_C_DRIVER_ENABLE, 8'h03);
        reg_read_chk("c input mix", `OFS_PORT_C_PIN_VALUE, 8'h0a);
        chk("c analog undriven", 8'h02, {4'h0, c_oe});
        reg_read_chk("unmapped", 16'h1234, 8'h00);
        // Reset in mid-run clears everything again
        do_reset();
        reset_state();
        close_out();
    end
endmodule : parallel_port_data_and_drive_test
`default_nettype wire
